// ===== design/sep_engine.sv
// two-wire serial eeprom protocol engine with an axi4-lite status port
module sep_engine #(
  parameter int unsigned PROG_CYCLES   = sep_pkg::PROG_CYCLES,
  parameter logic [3:0]  DEV_TYPE_CODE = 4'h5  // arbitrary value
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // two-wire link
  input  wire logic        SCL,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  input  wire logic [2:0]  CHIP_SELECT_STRAPS,
  // axi4-lite write
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  localparam int AW = sep_pkg::MEM_AW;
  localparam int PW = sep_pkg::PAGE_AW;
  localparam int CW = sep_pkg::PROG_CNT_W;
  localparam int CTRL_W = 1;

  logic                 scl_m, scl_s, scl_q;
  logic                 sda_m, sda_s, sda_q;
  logic [2:0]           strap_m, strap_s;
  logic                 start_cond, stop_cond, scl_rise, scl_fall;
  sep_pkg::sep_state_t  state;
  sep_pkg::sep_phase_t  phase;
  logic [3:0]           bit_cnt;
  logic [7:0]           shifter;
  logic [7:0]           tx_byte;
  logic                 drive_low;
  logic                 rd_mode, wr_mode, ack_low;
  logic [AW-1:0]        addr;
  logic [31:0]          mask;
  logic                 busy, copying;
  logic [CW-1:0]        prog_cnt;
  logic [5:0]           copy_idx;
  logic [AW-PW-1:0]     prog_page;
  logic [15:0]          prog_total;
  logic                 start_prog;
  logic                 pb_we, mem_we;
  logic [7:0]           pb_rdata, mem_rdata;
  logic [PW-1:0]        copy_prev;
  logic [31:0]          ctrl;
  logic                 aw_held, w_held;
  logic [7:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic [31:0]          next_rdata;
  logic                 next_rmapped;

  // link pins pass two flops before any logic sees them
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
    end
    else
    begin
      scl_m <= SCL;
      scl_s <= scl_m;
      scl_q <= scl_s;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      sda_m <= SDA_IN;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end

  // straps are static but still come from outside the clock domain
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      strap_m <= 3'h0;
      strap_s <= 3'h0;
    end
    else
    begin
      strap_m <= CHIP_SELECT_STRAPS;
      strap_s <= strap_m;
    end
  end

  // bus conditions; data is taken only while scl is high
  assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_cond  = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise   = scl_s & ~scl_q;
  assign scl_fall   = ~scl_s & scl_q;

  // open drain: the pin is only ever pulled low
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = drive_low;

  // protocol sequencer; start and stop override any byte in flight
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      state     <= sep_pkg::ST_IDLE;
      phase     <= sep_pkg::PH_DEV;
      bit_cnt   <= 4'h0;
      shifter   <= 8'h00;
      tx_byte   <= 8'h00;
      drive_low <= 1'b0;
      rd_mode   <= 1'b0;
      wr_mode   <= 1'b0;
      ack_low   <= 1'b0;
      addr      <= '0;
      mask      <= 32'h0000_0000;
    end
    else if (start_cond)
    begin
      state     <= sep_pkg::ST_RX;
      phase     <= sep_pkg::PH_DEV;
      bit_cnt   <= 4'h0;
      drive_low <= 1'b0;
      rd_mode   <= 1'b0;
      wr_mode   <= 1'b0;
    end
    else if (stop_cond)
    begin
      // stop ends any read or write and leaves the bus released
      state     <= sep_pkg::ST_IDLE;
      drive_low <= 1'b0;
      rd_mode   <= 1'b0;
      wr_mode   <= 1'b0;
    end
    else
    begin
      unique case (state)
        sep_pkg::ST_IDLE:
        begin
          drive_low <= 1'b0;
        end
        sep_pkg::ST_RX:
        begin
          if (scl_rise && bit_cnt != sep_pkg::BITS_PER_BYTE)
          begin
            shifter <= {shifter[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == sep_pkg::BITS_PER_BYTE)
          begin
            bit_cnt   <= 4'h0;
            state     <= sep_pkg::ST_RX_ACK;
            drive_low <= 1'b1;
            unique case (phase)
              sep_pkg::PH_DEV:
              begin
                if (shifter[7:4] != DEV_TYPE_CODE || shifter[3:1] != strap_s)
                begin
                  state     <= sep_pkg::ST_IDLE;
                  drive_low <= 1'b0;
                end
                else if (busy)
                begin
                  state     <= sep_pkg::ST_IDLE;
                  drive_low <= 1'b0;
                end
                else
                begin
                  rd_mode <= shifter[0];
                  wr_mode <= ~shifter[0];
                  phase   <= sep_pkg::PH_ADDR_HI;
                  if (!shifter[0])
                    mask <= 32'h0000_0000;
                end
              end
              sep_pkg::PH_ADDR_HI:
              begin
                addr[AW-1:8] <= shifter[AW-9:0];
                phase        <= sep_pkg::PH_ADDR_LO;
              end
              sep_pkg::PH_ADDR_LO:
              begin
                addr[7:0] <= shifter;
                phase     <= sep_pkg::PH_DATA;
              end
              sep_pkg::PH_DATA:
              begin
                // later bytes to the same slot simply overwrite it
                mask[addr[PW-1:0]] <= 1'b1;
                addr <= {addr[AW-1:PW], addr[PW-1:0] + {{(PW-1){1'b0}}, 1'b1}};
              end
            endcase
          end
        end
        sep_pkg::ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            if (rd_mode)
            begin
              state     <= sep_pkg::ST_TX;
              tx_byte   <= mem_rdata;
              drive_low <= ~mem_rdata[7];
            end
            else
            begin
              state     <= sep_pkg::ST_RX;
              drive_low <= 1'b0;
            end
          end
        end
        sep_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt[2:0] == sep_pkg::LAST_BIT)
            begin
              // release for the ninth clock and point at the next byte
              bit_cnt   <= 4'h0;
              drive_low <= 1'b0;
              state     <= sep_pkg::ST_TX_ACK;
              addr      <= addr + {{(AW-1){1'b0}}, 1'b1};
            end
            else
            begin
              bit_cnt   <= bit_cnt + 4'h1;
              tx_byte   <= {tx_byte[6:0], 1'b0};
              drive_low <= ~tx_byte[6];
            end
          end
        end
        sep_pkg::ST_TX_ACK:
        begin
          if (scl_rise)
            ack_low <= ~sda_s;
          else if (scl_fall)
          begin
            if (ack_low)
            begin
              state     <= sep_pkg::ST_TX;
              tx_byte   <= mem_rdata;
              drive_low <= ~mem_rdata[7];
            end
            else
              state <= sep_pkg::ST_HOLD;
          end
        end
        sep_pkg::ST_HOLD:
        begin
          // bus stays released until the master sends stop or start
          drive_low <= 1'b0;
        end
      endcase
    end
  end

  // data bytes land in the page buffer as they arrive
  assign pb_we = state == sep_pkg::ST_RX && scl_fall && !start_cond && !stop_cond
                 && bit_cnt == sep_pkg::BITS_PER_BYTE && phase == sep_pkg::PH_DATA;

  // a stop after write data starts programming unless software inhibits it
  assign start_prog = stop_cond && wr_mode && mask != 32'h0000_0000
                      && !ctrl[sep_pkg::CTRL_INHIBIT_BIT];

  // programming timer followed by a copy of the buffered page
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      busy      <= 1'b0;
      copying   <= 1'b0;
      prog_cnt  <= '0;
      copy_idx  <= 6'h00;
      prog_page <= '0;
    end
    else if (!busy)
    begin
      if (start_prog)
      begin
        busy      <= 1'b1;
        prog_cnt  <= CW'(PROG_CYCLES - 1);
        prog_page <= addr[AW-1:PW];
      end
    end
    else if (!copying)
    begin
      if (prog_cnt == '0)
      begin
        copying  <= 1'b1;
        copy_idx <= 6'h00;
      end
      else
        prog_cnt <= prog_cnt - {{(CW-1){1'b0}}, 1'b1};
    end
    else if (copy_idx == sep_pkg::PAGE_END)
    begin
      busy    <= 1'b0;
      copying <= 1'b0;
    end
    else
      copy_idx <= copy_idx + 6'h01;
  end

  // completed programming cycles, visible to software
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      prog_total <= 16'h0000;
    else if (copying && copy_idx == sep_pkg::PAGE_END)
      prog_total <= prog_total + 16'h0001;
  end

  // buffer read data lags its index by one cycle
  assign copy_prev = copy_idx[PW-1:0] - {{(PW-1){1'b0}}, 1'b1};
  assign mem_we    = copying && copy_idx != 6'h00 && mask[copy_prev];

  sep_mem #(.AW(PW)) u_page (
    .clk     (CLK),
    .wr_en   (pb_we),
    .wr_addr (addr[PW-1:0]),
    .wr_data (shifter),
    .rd_addr (copy_idx[PW-1:0]),
    .rd_data (pb_rdata)
  );

  sep_mem #(.AW(AW)) u_array (
    .clk     (CLK),
    .wr_en   (mem_we),
    .wr_addr ({prog_page, copy_prev}),
    .wr_data (pb_rdata),
    .rd_addr (addr),
    .rd_data (mem_rdata)
  );

  // axi write: address and data taken in either order, then one response
  assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_held & ~S_AXI_BVALID;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end
    else if (aw_held && w_held)
      aw_held <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end
    else if (aw_held && w_held)
      w_held <= 1'b0;
  end

  // only the control word is writable; other addresses answer slverr
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= sep_pkg::RESP_OKAY;
      ctrl         <= sep_pkg::CTRL_RST;
    end
    else if (aw_held && w_held)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= sep_pkg::RESP_SLVERR;
      if (aw_addr == sep_pkg::CTRL_OFS)
      begin
        S_AXI_BRESP <= sep_pkg::RESP_OKAY;
        if (w_strb[0])
          ctrl[CTRL_W-1:0] <= w_data[CTRL_W-1:0];
      end
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // read decode of block state
  always_comb
  begin
    next_rdata   = 32'h0000_0000;
    next_rmapped = 1'b1;
    unique case (S_AXI_ARADDR)
      sep_pkg::CTRL_OFS:
        next_rdata = ctrl;
      sep_pkg::STATUS_OFS:
      begin
        next_rdata[sep_pkg::ST_BUSY_BIT]  = busy;
        next_rdata[sep_pkg::ST_READ_BIT]  = rd_mode;
        next_rdata[sep_pkg::ST_WRITE_BIT] = wr_mode;
        next_rdata[sep_pkg::ST_SEL_LSB +: 3] = strap_s;
      end
      sep_pkg::ADDR_OFS:
        next_rdata[AW-1:0] = addr;
      sep_pkg::COUNT_OFS:
        next_rdata[15:0] = prog_total;
      default:
        next_rmapped = 1'b0;
    endcase
  end

  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  // read answer registered one cycle after the address is taken
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= sep_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= next_rdata;
      S_AXI_RRESP  <= next_rmapped ? sep_pkg::RESP_OKAY : sep_pkg::RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end
endmodule : sep_engine

// ===== design/sep_pkg.sv
// shared constants for the serial eeprom protocol engine
package sep_pkg;
  // memory geometry
  localparam int MEM_AW    = 13;
  localparam int PAGE_AW   = 5;
  localparam int PAGE_SIZE = 32;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam logic [5:0] PAGE_END      = 6'h20;
  // programming time, in milliseconds and in clock cycles
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned T_PROG_MS   = 10;
  localparam int unsigned PROG_CYCLES = T_PROG_MS * (CLK_HZ / 1000);
  localparam int PROG_CNT_W = 20;
  // register map, byte addresses
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] ADDR_OFS   = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0C;
  // field positions and reset values
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int ST_BUSY_BIT      = 0;
  localparam int ST_READ_BIT      = 1;
  localparam int ST_WRITE_BIT     = 2;
  localparam int ST_SEL_LSB       = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // protocol states and byte phases
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_HOLD} sep_state_t;
  typedef enum logic [1:0] {PH_DEV, PH_ADDR_HI, PH_ADDR_LO, PH_DATA} sep_phase_t;
endpackage : sep_pkg

// ===== design/sep_mem.sv
// byte-wide memory with one write port and a registered read port
module sep_mem #(
  parameter int AW = 13
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [0:(1<<AW)-1];

  // storage write
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // read data always from a register
  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule : sep_mem

// ===== verif/sep_engine_asserts.sv
// port assertions for the serial eeprom protocol engine
module sep_engine_asserts (
  // clock and reset
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // two-wire link
  input wire logic        SCL,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE,
  // axi4-lite write
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  // axi4-lite read
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // only the control word takes writes; four words answer reads
  logic aw_bad;
  logic ar_bad;
  assign aw_bad = S_AXI_AWADDR != sep_pkg::CTRL_OFS;
  assign ar_bad = !(S_AXI_ARADDR inside {sep_pkg::CTRL_OFS, sep_pkg::STATUS_OFS,
                                         sep_pkg::ADDR_OFS, sep_pkg::COUNT_OFS});
  sequence s_wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  property p_reset;
    disable iff (1'b0) SYS_RST |=> !SDA_OE && !S_AXI_BVALID && !S_AXI_RVALID && S_AXI_ARREADY;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle after reset");
  property p_open_drain;
    SDA_OUT == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  // the device only moves the data line while the clock is low
  property p_oe_scl_low;
    $changed(SDA_OE) |-> !SCL;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
  property p_wr_answer;
    s_wr_take |-> ##[1:3] S_AXI_BVALID;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  property p_wr_err;
    s_wr_take ##0 aw_bad |-> ##[1:3] (S_AXI_BVALID && S_AXI_BRESP == sep_pkg::RESP_SLVERR);
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("bad write address not refused");
  property p_rd_answer;
    s_rd_take |=> S_AXI_RVALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response late");
  property p_rd_err;
    s_rd_take ##0 ar_bad |=> S_AXI_RRESP == sep_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("bad read address not refused");
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_b_block;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken while response pending");
endmodule : sep_engine_asserts

bind sep_engine sep_engine_asserts u_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
);

// ===== verif/sep_master.sv
// two-wire bus master model driving clock and data
module sep_master (
  // clock
  input wire logic clk,
  // resolved data wire
  input wire logic sda,
  // pull high holds the data wire low
  output logic     scl,
  output logic     pull
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one bit of 8 cycles: data moves mid-low, sampled mid-high
  task automatic slot(input logic b, output logic s);
    scl <= 1'b0;
    tick(2);
    pull <= !b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    @(negedge clk);
    s = sda;
    tick(2);
  endtask : slot
  // start or stop; clock dips first so a device ack is let go
  task automatic mark(input logic is_stop);
    scl <= 1'b0;
    tick(2);
    pull <= is_stop;
    tick(2);
    scl <= 1'b1;
    tick(4);
    pull <= !is_stop;
    tick(4);
  endtask : mark
  // byte out msb first, then the ninth slot released
  task automatic wbyte(input logic [7:0] d, output logic ak);
    logic s;
    for (int i = 7; i >= 0; i--)
      slot(d[i], s);
    slot(1'b1, ak);
  endtask : wbyte
  // byte in, then the master's ack; high ends a read
  task automatic rbyte(input logic ak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      slot(1'b1, s);
      d[i] = s;
    end
    slot(ak, s);
  endtask : rbyte
endmodule : sep_master

// ===== verif/sep_engine_tb.sv
// self-checking bench for the serial eeprom protocol engine
module sep_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] TYPE = 4'h9; // arbitrary value
  localparam logic [2:0] SEL  = 3'h6; // asymmetric, so a reversed order shows
  localparam logic [7:0] DW   = {TYPE, SEL, 1'b0};
  logic        clk, rst, scl, pull, sda, sda_out, sda_oe, a;
  logic [2:0]  straps;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  q[$];
  logic [31:0] rv [4] = '{32'h0, 32'h60, 32'h0, 32'h0};
  logic [7:0]  bad [2] = '{{~TYPE, SEL, 1'b0}, {TYPE, 3'h3, 1'b1}};
  int          error_cnt, check_count;
  // open-drain wire with a pull-up
  assign sda = !(pull || sda_oe);
  sep_engine #(.PROG_CYCLES(200), .DEV_TYPE_CODE(TYPE)) u_dut (
    .CLK(clk), .SYS_RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .CHIP_SELECT_STRAPS(straps), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );
  sep_master u_mst (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // one axi4-lite access; each request stands until its ready is sampled
  task automatic axi(input logic wr, input logic [7:0] ad, input logic [31:0] dt,
                     output logic [31:0] rd, output logic [1:0] rs);
    logic ta, tw, tb;
    awaddr <= ad;
    araddr <= ad;
    wdata <= dt;
    {awvalid, wvalid, bready} <= {3{wr}};
    {arvalid, rready} <= {2{!wr}};
    do
    begin
      @(negedge clk);
      ta = wr ? awvalid && awready : arvalid && arready;
      tw = wvalid && wready;
      tb = wr ? bvalid : rvalid;
      rd = rdata;
      rs = wr ? bresp : rresp;
      @(posedge clk);
      awvalid <= awvalid && !ta;
      arvalid <= arvalid && !ta;
      wvalid <= wvalid && !tw;
    end while (!tb);
    {bready, rready} <= 2'h0;
    // let an edge pass so the next call never re-drives a released ready
    @(posedge clk);
  endtask : axi
  task automatic dev(input logic [7:0] w, output logic ak);
    u_mst.mark(1'b0);
    u_mst.wbyte(w, ak);
  endtask : dev
  // write n bytes b, b+1, ... from address ad, then stop
  task automatic wr_page(input logic [12:0] ad, input int n, input logic [7:0] b);
    logic ak;
    dev(DW, ak);
    chk("dev ack", ak, 32'h0);
    u_mst.wbyte({3'h0, ad[12:8]}, ak);
    u_mst.wbyte(ad[7:0], ak);
    chk("addr ack", ak, 32'h0);
    for (int k = 0; k < n; k++)
    begin
      u_mst.wbyte(b + 8'(k), ak);
      chk("data ack", ak, 32'h0);
    end
    u_mst.mark(1'b1);
  endtask : wr_page
  // poll the address word until the device acks again
  task automatic poll;
    logic ak;
    int n;
    ak = 1'b1;
    n = 0;
    while (ak && n < 20)
    begin
      dev(DW, ak);
      u_mst.mark(1'b1);
      n++;
    end
    chk("poll", ak, 32'h0);
  endtask : poll
  // dummy write, repeated start, read the bytes queued in q
  task automatic rd_seq(input logic [12:0] ad);
    logic ak;
    logic [7:0] d;
    dev(DW, ak);
    u_mst.wbyte({3'h0, ad[12:8]}, ak);
    u_mst.wbyte(ad[7:0], ak);
    dev(DW | 8'h01, ak);
    chk("read ack", ak, 32'h0);
    foreach (q[i])
    begin
      u_mst.rbyte(i == q.size() - 1, d);
      chk("read data", d, q[i]);
    end
    u_mst.rbyte(1'b1, d);
    chk("released", d, 32'hFF);
    u_mst.mark(1'b1);
    q.delete();
  endtask : rd_seq
  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr} = 16'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    straps = SEL;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    foreach (rv[k])
    begin
      axi(1'b0, 8'(k * 4), 32'h0, v, r);
      chk("reset value", v, rv[k]);
    end
    axi(1'b0, 8'h10, 32'h0, v, r);
    chk("rresp", r, sep_pkg::RESP_SLVERR);
    axi(1'b1, 8'h10, 32'h1, v, r);
    chk("bresp", r, sep_pkg::RESP_SLVERR);
    axi(1'b1, sep_pkg::CTRL_OFS, 32'h1, v, r);
    axi(1'b0, sep_pkg::CTRL_OFS, 32'h0, v, r);
    chk("ctrl", v, 32'h1);
    // a write without byte lane 0 must leave the control word alone
    wstrb <= 4'h0;
    axi(1'b1, sep_pkg::CTRL_OFS, 32'h0, v, r);
    wstrb <= 4'hF;
    axi(1'b0, sep_pkg::CTRL_OFS, 32'h0, v, r);
    chk("ctrl strobe", v, 32'h1);
    // inhibited write leaves the device idle
    wr_page(13'h0000, 1, 8'h11);
    dev(DW, a);
    chk("idle ack", a, 32'h0);
    u_mst.mark(1'b1);
    axi(1'b0, sep_pkg::COUNT_OFS, 32'h0, v, r);
    chk("count", v, 32'h0);
    axi(1'b1, sep_pkg::CTRL_OFS, 32'h0, v, r);
    $display("test registers done");
    // another strap setting moves the select code the device answers to
    straps <= 3'h1;
    dev({TYPE, 3'h1, 1'b0}, a);
    u_mst.mark(1'b1);
    chk("strap ack", a, 32'h0);
    axi(1'b0, sep_pkg::STATUS_OFS, 32'h0, v, r);
    chk("strap value", v, 32'h10);
    straps <= SEL;
    foreach (bad[k])
    begin
      dev(bad[k], a);
      u_mst.mark(1'b1);
      chk("nack", a, 32'h1);
    end
    axi(1'b0, sep_pkg::STATUS_OFS, 32'h0, v, r);
    chk("standby", v, 32'h60);
    $display("test address word done");
    // 33 bytes from index 30: wraps, index 30 rewritten
    wr_page(13'h013E, 33, 8'h00);
    dev(DW | 8'h01, a);
    chk("busy nack", a, 32'h1);
    u_mst.mark(1'b1);
    axi(1'b0, sep_pkg::STATUS_OFS, 32'h0, v, r);
    chk("busy", v[0], 32'h1);
    poll();
    axi(1'b0, sep_pkg::COUNT_OFS, 32'h0, v, r);
    chk("count", v, 32'h1);
    q = '{8'h1F, 8'h20, 8'h01};
    rd_seq(13'h013D);
    $display("test page write done");
    wr_page(13'h1FFF, 1, 8'h3C);
    poll();
    wr_page(13'h0000, 1, 8'hC3);
    poll();
    axi(1'b0, sep_pkg::COUNT_OFS, 32'h0, v, r);
    chk("count", v, 32'h3);
    q = '{8'h3C, 8'hC3};
    rd_seq(13'h1FFF);
    // pointer stepped past both bytes sent, wrapping through zero
    axi(1'b0, sep_pkg::ADDR_OFS, 32'h0, v, r);
    chk("addr", v, 32'h1);
    $display("test rollover done");
    test_done();
  end
  // watchdog, well past the expected run length
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : sep_engine_tb
